//--- rtl/htc_regs.vh
`ifndef HTC_REGS_VH
`define HTC_REGS_VH
// fixed bus address of the sensor
`define HTC_DEV_ADDR      7'h40
// command codes
`define HTC_CMD_T_HOLD    8'hE3
`define HTC_CMD_H_HOLD    8'hE5
`define HTC_CMD_T_POLL    8'hF3
`define HTC_CMD_H_POLL    8'hF5
`define HTC_CMD_UREG_WR   8'hE6
`define HTC_CMD_UREG_RD   8'hE7
`define HTC_CMD_SOFT_RST  8'hFE
// user register layout and reset value
`define HTC_UREG_RST      8'h00
`define HTC_UREG_RES_HI   7
`define HTC_UREG_LOWBAT   6
`define HTC_UREG_HEATER   2
`define HTC_UREG_RES_LO   0
// status bit in the low result byte
`define HTC_STAT_TYPE     1
// timing, in ms, and the clock rate in kHz
`define HTC_CLK_KHZ       25000
`define HTC_T_BOOT_MS     15
`define HTC_T_CONV14_MS   7'h55
`define HTC_T_CONV13_MS   7'h2B
`define HTC_T_CONV12_MS   7'h16
`define HTC_T_CONV11_MS   7'h0B
`define HTC_T_CONV10_MS   7'h06
`define HTC_T_CONV8_MS    7'h03
`endif

//--- rtl/htc_i2c_port.v
// Notes on behaviour
// [R1] ready for commands within 15 ms of power
// [R2] master frames transfers with start and stop
// [R3] answer only address 1000000 plus direction
// [R4] ack low after eighth falling clock edge
// [R5] E3/E5 start clock-stretched temperature/humidity conversion
// [R6] F3/F5 start polled temperature/humidity conversion
// [R7] E6 writes, E7 reads the user register
// [R8] hold clock low until stretched conversion ends
// [R9] polled conversion leaves the clock line free
// [R10] master polls with read header 10000001
// [R11] ack read header only when result ready
// [R12] busy poll leaves header ack slot undriven
// [R13] low two result bits carry status
// [R14] status bit 1: 0 temperature, 1 humidity
// [R15] master may stop before the checksum byte
// [R16] conversion 85/43/22 ms at 14/13/12 bits
// [R17] lower resolutions 11/6/3 ms
// [R18] soft reset restores defaults under 15 ms
// [R19] default resolution 12-bit humidity, 14-bit temperature
// [R20] bytes move msb first, each acknowledged
// [R21] master keeps reserved bits unchanged
// [R22] low-supply bit refreshed after each conversion
// [R23] result: msb, lsb, optional checksum
// [R24] stretched read uses repeated start, read header
`timescale 1ns/1ps
`default_nettype none
`include "htc_regs.vh"
module htc_i2c_port #(
   parameter integer   MS_CYC   = `HTC_CLK_KHZ,
   parameter [7:0]     CRC_POLY = 8'h31
) (
   input  wire         clock,
   input  wire         sys_rst,
   input  wire         clk_en,
   input  wire         scl_in,
   output wire         scl_out,
   output wire         scl_oe_n,
   input  wire         sda_in,
   output wire         sda_out,
   output wire         sda_oe_n,
   input  wire [13:0]  sample_data,
   input  wire         low_supply,
   output reg          conv_busy_r,
   output reg          conv_humid_r,
   output wire         heater_en,
   output wire [1:0]   resolution,
   output wire         ready
);
   localparam [2:0] S_IDLE = 3'h0, S_RX = 3'h1, S_RXACK = 3'h2, S_TX = 3'h3,
                    S_TXACK = 3'h4, S_HOLD = 3'h5, S_WAIT = 3'h6;
   localparam [1:0] N_RX = 2'h0, N_TX = 2'h1, N_HOLD = 2'h2, N_BOOT = 2'h3;
   localparam [1:0] SRC_NONE = 2'h0, SRC_UREG = 2'h1, SRC_RES = 2'h2;
   localparam integer BOOT_CYC = `HTC_T_BOOT_MS * MS_CYC - 1;

   reg  [2:0]  scl_s_r, sda_s_r;
   reg  [2:0]  st_r;
   reg  [3:0]  bit_r;
   reg  [7:0]  sh_r;
   reg  [1:0]  phase_r, nxt_r, src_r, byte_r;
   reg         sda_lo_r, scl_lo_r, more_r, hold_r, res_valid_r;
   reg  [7:0]  ureg_r;
   reg  [15:0] res_r;
   reg  [23:0] conv_cnt_r, boot_cnt_r;
   reg  [6:0]  conv_ms;
   reg  [3:0]  conv_bits;
   reg  [7:0]  crc;
   reg  [7:0]  tx_byte;
   reg  [7:0]  tx_nxt;
   wire [31:0] conv_cyc;
   wire [13:0] res_mask;
   wire        scl_h, sda_h, scl_rise, scl_fall, start_c, stop_c, booting;
   integer     i;

   // only the second and third stages are looked at; the first is metastable
   assign scl_h    = scl_s_r[1];
   assign sda_h    = sda_s_r[1];
   assign scl_rise = scl_h & ~scl_s_r[2];
   assign scl_fall = ~scl_h & scl_s_r[2];
   assign start_c  = scl_h & scl_s_r[2] & ~sda_h & sda_s_r[2]; // [R2]
   assign stop_c   = scl_h & scl_s_r[2] & sda_h & ~sda_s_r[2]; // [R2]
   assign booting  = (boot_cnt_r != 24'h000000);
   assign ready    = ~booting;
   assign heater_en  = ureg_r[`HTC_UREG_HEATER];
   assign resolution = {ureg_r[`HTC_UREG_RES_HI], ureg_r[`HTC_UREG_RES_LO]};

   // open-drain pins: only ever pull low
   assign scl_out  = 1'b0;
   assign sda_out  = 1'b0;
   assign scl_oe_n = ~scl_lo_r;
   assign sda_oe_n = ~sda_lo_r;

   // worst-case conversion time and resolution for the pending kind
   always @* begin
      case ({conv_humid_r, resolution})
         3'h0:    begin conv_ms = `HTC_T_CONV14_MS; conv_bits = 4'hE; end // [R16] [R19]
         3'h1:    begin conv_ms = `HTC_T_CONV12_MS; conv_bits = 4'hC; end // [R16]
         3'h2:    begin conv_ms = `HTC_T_CONV13_MS; conv_bits = 4'hD; end // [R16]
         3'h4:    begin conv_ms = `HTC_T_CONV12_MS; conv_bits = 4'hC; end // [R19]
         3'h5:    begin conv_ms = `HTC_T_CONV8_MS;  conv_bits = 4'h8; end // [R17]
         3'h6:    begin conv_ms = `HTC_T_CONV10_MS; conv_bits = 4'hA; end // [R17]
         default: begin conv_ms = `HTC_T_CONV11_MS; conv_bits = 4'hB; end // [R17]
      endcase
   end
   assign conv_cyc = conv_ms * MS_CYC;
   // open low bits of a reduced-resolution sample read as zero
   assign res_mask = 14'h3FFF << (4'hE - conv_bits);

   // checksum over the two result bytes, msb first
   always @* begin
      crc = 8'h00;
      for (i = 15; i >= 0; i = i - 1) begin
         if (crc[7] ^ res_r[i]) begin
            crc = {crc[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            crc = {crc[6:0], 1'b0};
         end
      end
   end

   // byte to send next, by source and index
   always @* begin
      if (src_r == SRC_UREG) begin
         tx_byte = ureg_r;
      end else begin
         case (byte_r)
            2'h0:    tx_byte = res_r[15:8]; // [R23]
            2'h1:    tx_byte = res_r[7:0];  // [R23]
            default: tx_byte = crc;         // [R23]
         endcase
      end
   end

   // byte that follows the current result byte
   always @* begin
      case (byte_r)
         2'h0:    tx_nxt = res_r[7:0];  // [R23]
         default: tx_nxt = crc;         // [R23]
      endcase
   end

   // pin synchronisers
   always @(posedge clock) begin
      if (sys_rst) begin
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
      end else if (clk_en) begin
         scl_s_r <= {scl_s_r[1:0], scl_in};
         sda_s_r <= {sda_s_r[1:0], sda_in};
      end
   end

   // conversion engine, boot timer and user register
   always @(posedge clock) begin
      if (sys_rst) begin
         boot_cnt_r   <= BOOT_CYC[23:0];                   // [R1]
         conv_cnt_r   <= 24'h000000;
         conv_busy_r  <= 1'b0;
         conv_humid_r <= 1'b0;
         res_valid_r  <= 1'b0;
         res_r        <= 16'h0000;
         ureg_r       <= `HTC_UREG_RST;
      end else if (clk_en) begin
         if (booting) begin
            boot_cnt_r  <= boot_cnt_r - 24'h000001;
            conv_busy_r <= 1'b0;
            res_valid_r <= 1'b0;
            ureg_r      <= `HTC_UREG_RST;                  // [R18] [R19]
         end else if (st_r == S_RXACK && scl_fall && nxt_r == N_BOOT) begin
            boot_cnt_r  <= BOOT_CYC[23:0];                 // [R18]
         end
         if (!booting && st_r == S_RX && scl_fall && bit_r == 4'h8 && phase_r == 2'h1) begin
            if ((sh_r == `HTC_CMD_T_HOLD || sh_r == `HTC_CMD_H_HOLD ||
                 sh_r == `HTC_CMD_T_POLL || sh_r == `HTC_CMD_H_POLL) && !conv_busy_r) begin
               conv_busy_r  <= 1'b1;                       // [R5] [R6]
               conv_humid_r <= sh_r[2];
               res_valid_r  <= 1'b0;
            end
         end else if (!booting && st_r == S_RX && scl_fall && bit_r == 4'h8 && phase_r == 2'h2) begin
            ureg_r <= {sh_r[7], ureg_r[6], sh_r[5:0]};     // [R7] low-supply is read-only
         end
         // counter is loaded on the cycle after the command, once the kind is known
         if (conv_busy_r && conv_cnt_r == 24'h000000 && !res_valid_r) begin
            conv_cnt_r <= conv_cyc[23:0];
            res_valid_r <= 1'b1;                           // marks counter armed
         end else if (conv_busy_r && conv_cnt_r == 24'h000002) begin
            // ends two cycles early so start and arming stay inside the limit
            conv_cnt_r  <= 24'h000000;
            conv_busy_r <= 1'b0;
            res_r <= {sample_data & res_mask, conv_humid_r, 1'b0}; // [R13] [R14]
            ureg_r[`HTC_UREG_LOWBAT] <= low_supply;        // [R22]
         end else if (conv_cnt_r != 24'h000000) begin
            conv_cnt_r <= conv_cnt_r - 24'h000001;
         end
         // a started result read consumes the result
         if (st_r == S_TX && src_r == SRC_RES && byte_r == 2'h0 && !conv_busy_r) begin
            res_valid_r <= 1'b0;
         end
      end
   end

   // bus protocol engine
   always @(posedge clock) begin
      if (sys_rst) begin
         st_r <= S_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; phase_r <= 2'h0;
         nxt_r <= N_RX; src_r <= SRC_NONE; byte_r <= 2'h0; more_r <= 1'b0;
         hold_r <= 1'b0; sda_lo_r <= 1'b0; scl_lo_r <= 1'b0;
      end else if (clk_en) begin
         if (booting) begin
            st_r <= S_IDLE; sda_lo_r <= 1'b0; scl_lo_r <= 1'b0; src_r <= SRC_NONE; // [R1]
         end else if (start_c && st_r != S_HOLD) begin
            st_r <= S_RX; bit_r <= 4'h0; phase_r <= 2'h0; sda_lo_r <= 1'b0;
         end else if (stop_c && st_r != S_HOLD) begin
            st_r <= S_IDLE; sda_lo_r <= 1'b0;
         end else begin
            case (st_r)
               S_RX: begin
                  if (scl_rise && bit_r != 4'h8) begin
                     sh_r  <= {sh_r[6:0], sda_h};          // [R20]
                     bit_r <= bit_r + 4'h1;
                  end else if (scl_fall && bit_r == 4'h8) begin
                     st_r <= S_RXACK; sda_lo_r <= 1'b1; nxt_r <= N_RX;  // [R4]
                     bit_r <= 4'h0;
                     if (phase_r == 2'h0) begin
                        if (sh_r[7:1] != `HTC_DEV_ADDR) begin
                           st_r <= S_WAIT; sda_lo_r <= 1'b0;          // [R3]
                        end else if (!sh_r[0]) begin
                           phase_r <= 2'h1;
                        end else if (src_r == SRC_UREG) begin
                           nxt_r <= N_TX;                             // [R7]
                        end else if (src_r == SRC_RES && conv_busy_r && hold_r) begin
                           nxt_r <= N_HOLD;                           // [R8] [R24]
                        end else if (src_r == SRC_RES && !conv_busy_r && res_valid_r) begin
                           nxt_r <= N_TX;                             // [R11]
                        end else begin
                           st_r <= S_WAIT; sda_lo_r <= 1'b0;          // [R11] [R12]
                        end
                     end else if (phase_r == 2'h1) begin
                        phase_r <= 2'h3;
                        case (sh_r)
                           `HTC_CMD_T_HOLD, `HTC_CMD_H_HOLD: begin
                              src_r <= SRC_RES; hold_r <= 1'b1;         // [R5]
                           end
                           `HTC_CMD_T_POLL, `HTC_CMD_H_POLL: begin
                              src_r <= SRC_RES; hold_r <= 1'b0;         // [R6] [R9]
                           end
                           `HTC_CMD_UREG_WR: phase_r <= 2'h2;           // [R7]
                           `HTC_CMD_UREG_RD: src_r <= SRC_UREG;         // [R7]
                           `HTC_CMD_SOFT_RST: nxt_r <= N_BOOT;          // [R18]
                           default: begin
                              st_r <= S_WAIT; sda_lo_r <= 1'b0;
                           end
                        endcase
                     end else if (phase_r == 2'h2) begin
                        phase_r <= 2'h3;
                     end else begin
                        st_r <= S_WAIT; sda_lo_r <= 1'b0;
                     end
                  end
               end
               S_RXACK: begin
                  if (scl_fall) begin
                     byte_r <= 2'h0;
                     case (nxt_r)
                        N_TX: begin
                           st_r <= S_TX; sda_lo_r <= ~tx_byte[7];
                           sh_r <= {tx_byte[6:0], 1'b0}; bit_r <= 4'h1;
                        end
                        N_HOLD: begin
                           st_r <= S_HOLD; sda_lo_r <= 1'b0; scl_lo_r <= 1'b1; // [R8]
                        end
                        N_BOOT: begin
                           st_r <= S_IDLE; sda_lo_r <= 1'b0;
                        end
                        default: begin
                           st_r <= S_RX; sda_lo_r <= 1'b0;
                        end
                     endcase
                  end
               end
               S_HOLD: begin
                  // clock held low; first bit set up before the release
                  // data set one cycle ahead so it never moves with the clock high
                  if (!conv_busy_r && bit_r == 4'h1) begin
                     st_r <= S_TX; scl_lo_r <= 1'b0;                   // [R8]
                  end else if (!conv_busy_r) begin
                     sda_lo_r <= ~tx_byte[7];
                     sh_r <= {tx_byte[6:0], 1'b0}; bit_r <= 4'h1;
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bit_r == 4'h8) begin
                        st_r <= S_TXACK; sda_lo_r <= 1'b0;
                     end else begin
                        sda_lo_r <= ~sh_r[7];                         // [R20]
                        sh_r  <= {sh_r[6:0], 1'b0};
                        bit_r <= bit_r + 4'h1;
                     end
                  end
               end
               S_TXACK: begin
                  if (scl_rise) begin
                     more_r <= ~sda_h;
                  end else if (scl_fall) begin
                     if (more_r && src_r == SRC_RES && byte_r != 2'h2) begin
                        st_r <= S_TX; byte_r <= byte_r + 2'h1;         // [R23]
                        sda_lo_r <= ~tx_nxt[7];
                        sh_r  <= {tx_nxt[6:0], 1'b0};
                        bit_r <= 4'h1;
                     end else begin
                        st_r <= S_WAIT;                               // [R15]
                     end
                  end
               end
               default: st_r <= st_r;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/htc_i2c_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module htc_i2c_port_chk #(
   parameter integer MS_CYC = 25000
) (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        clk_en,
   input wire logic        scl_in,
   input wire logic        scl_out,
   input wire logic        scl_oe_n,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe_n,
   input wire logic [13:0] sample_data,
   input wire logic        low_supply,
   input wire logic        conv_busy_r,
   input wire logic        conv_humid_r,
   input wire logic        heater_en,
   input wire logic [1:0]  resolution,
   input wire logic        ready
);
   int boot_r;
   int busy_r;
   // millisecond waits are counted, far too long for repetition
   always @(posedge clock) begin
      boot_r <= (sys_rst || ready) ? 0 : boot_r + 1;
      busy_r <= (sys_rst || !conv_busy_r) ? 0 : busy_r + 1;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   sequence s_busy2;
      conv_busy_r ##1 conv_busy_r;
   endsequence
   // boot window and quiet pins before ready
   property p_boot; boot_r <= 15 * MS_CYC; endproperty
   a_boot: assert property (p_boot) else $error("not ready in time");
   property p_quiet; !ready |-> scl_oe_n && sda_oe_n; endproperty
   a_quiet: assert property (p_quiet) else $error("pins driven before ready");
   property p_dflt; $past(sys_rst) |-> resolution == 2'h0 && !heater_en; endproperty
   a_dflt: assert property (p_dflt) else $error("bad default settings");
   // clock holding only while a conversion runs or within two cycles of its end
   property p_stretch; !scl_oe_n |-> conv_busy_r || $past(conv_busy_r, 2); endproperty
   a_stretch: assert property (p_stretch) else $error("clock held while idle");
   property p_scl_low; !scl_oe_n |-> !scl_out; endproperty
   a_scl_low: assert property (p_scl_low) else $error("clock driven high");
   property p_sda_low; !sda_oe_n |-> !sda_out; endproperty
   a_sda_low: assert property (p_sda_low) else $error("data driven high");
   // data line only moves while the clock is low, never a false start or stop
   property p_sda_edge; $changed(sda_oe_n) |-> !scl_in; endproperty
   a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");
   property p_kind; s_busy2 |-> $stable(conv_humid_r); endproperty
   a_kind: assert property (p_kind) else $error("type changed mid conversion");
   property p_conv; busy_r <= 85 * MS_CYC; endproperty
   a_conv: assert property (p_conv) else $error("conversion too long");
endmodule
`default_nettype wire

//--- tb/htc_mst_model.sv
`timescale 1ns/1ps
`default_nettype none
module htc_mst_model (
   input  wire logic scl,
   input  wire logic sda,
   output var logic  scl_lo,
   output var logic  sda_lo
);
   localparam time HALF = 160;
   // both lines released at power up, clock left high for boot
   initial begin
      scl_lo = 1'h0;
      sda_lo = 1'h0;
   end
   // release clock and wait out any holding by the device
   task automatic rise();
      scl_lo = 1'h0;
      wait (scl === 1'h1);
      #HALF;
   endtask
   // data falls while clock high, also used as repeated start
   task automatic start();
      sda_lo = 1'h0;
      #(HALF / 2);
      rise();
      sda_lo = 1'h1;
      #HALF;
      scl_lo = 1'h1;
      #HALF;
   endtask
   task automatic stop();
      sda_lo = 1'h1;
      #(HALF / 2);
      rise();
      sda_lo = 1'h0;
      #HALF;
   endtask
   // eight bits msb first, then the ack slot; data moves mid low phase
   task automatic frame(input logic [8:0] o, output logic [8:0] i);
      for (int k = 8; k >= 0; k--) begin
         sda_lo = !o[k];
         #(HALF / 2);
         rise();
         i[k] = sda;
         scl_lo = 1'h1;
         #(HALF / 2);
      end
   endtask
endmodule
`default_nettype wire

//--- tb/htc_i2c_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "htc_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module htc_i2c_port_bench;
   localparam integer MS_CYC = 8;
   logic        clock = 1'h0;
   logic        sys_rst = 1'h1;
   logic        clk_en = 1'h1;
   logic        low_supply = 1'h0;
   logic [13:0] sample_data = 14'h0000;
   logic        scl_lo, sda_lo, ak;
   logic [7:0]  cmds [4] = '{`HTC_CMD_T_HOLD, `HTC_CMD_H_HOLD, `HTC_CMD_T_POLL, `HTC_CMD_H_POLL};
   wire logic   scl_out, scl_oe_n, sda_out, sda_oe_n, conv_busy_r, conv_humid_r, heater_en, ready;
   wire logic [1:0] resolution;
   // open-drain lines with pull-ups: low if anyone pulls
   wire logic   scl_w = !scl_lo && (scl_oe_n || scl_out);
   wire logic   sda_w = !sda_lo && (sda_oe_n || sda_out);
   int          fails = 0, n_checks = 0, cyc = 0;

   htc_mst_model m (.scl(scl_w), .sda(sda_w), .scl_lo(scl_lo), .sda_lo(sda_lo));
   htc_i2c_port #(.MS_CYC(MS_CYC)) dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sample_data(sample_data),
      .low_supply(low_supply), .conv_busy_r(conv_busy_r), .conv_humid_r(conv_humid_r),
      .heater_en(heater_en), .resolution(resolution), .ready(ready));

   always #20 clock = ~clock;
   // hang guard, well above boot plus four worst-case conversions
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   task end_sim;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // byte transfers, ack sampled in the ninth slot
   task automatic wr(input logic [7:0] d, output logic a);
      logic [8:0] r;
      m.frame({d, 1'h1}, r);
      a = (r[0] === 1'h0);
   endtask
   task automatic rd(input logic a, output logic [7:0] d);
      logic [8:0] r;
      m.frame({8'hFF, !a}, r);
      d = r[8:1];
   endtask
   task automatic head(input logic [7:0] c);
      logic a;
      m.start();
      wr({`HTC_DEV_ADDR, 1'h0}, a);
      `CHK(a, 1'h1)
      wr(c, a);
      `CHK(a, 1'h1)
   endtask
   task automatic ureg_rd(input logic [7:0] e);
      logic [7:0] d;
      head(`HTC_CMD_UREG_RD);
      m.start();
      wr({`HTC_DEV_ADDR, 1'h1}, ak);
      rd(1'h0, d);
      m.stop();
      `CHK(d, e)
   endtask
   task automatic ureg_wr(input logic [7:0] v);
      head(`HTC_CMD_UREG_WR);
      wr(v, ak);
      `CHK(ak, 1'h1)
      m.stop();
   endtask
   // one measurement; bit 4 of the code selects polled completion
   task automatic meas(input logic [7:0] c, input logic [13:0] s, input logic hum);
      logic [7:0] msb, lsb;
      int         n;
      n = 0;
      head(c);
      if (c[4]) begin
         m.stop();
         `CHK(scl_oe_n, 1'h1)
         ak = 1'h0;
         while (!ak && n < 200) begin
            m.start();
            wr({`HTC_DEV_ADDR, 1'h1}, ak);
            if (!ak) begin
               m.stop();
               n++;
            end
         end
         `CHK(n > 0, 1'h1)
      end else begin
         m.start();
         wr({`HTC_DEV_ADDR, 1'h1}, ak);
         `CHK(conv_busy_r, 1'h1)
         `CHK(conv_humid_r, hum)
      end
      `CHK(ak, 1'h1)
      rd(1'h1, msb);
      rd(1'h0, lsb);
      m.stop();
      `CHK({msb, lsb[7:2]}, hum ? {s[13:2], 2'h0} : s)
      `CHK(lsb[1], hum)
   endtask

   initial begin
      repeat (3) @(posedge clock);
      #1 sys_rst = 1'h0;
      while (!ready && cyc < 15 * MS_CYC + 4) @(posedge clock);
      `CHK(ready, 1'h1)
      ureg_rd(`HTC_UREG_RST);
      `CHK({heater_en, resolution}, 3'h0)
      m.start();
      wr(8'h90, ak);
      `CHK(ak, 1'h0)
      m.stop();
      ureg_wr(8'h05);
      `CHK({heater_en, resolution}, 3'h5)
      ureg_rd(8'h05);
      ureg_wr(8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         #1 low_supply = i[1];
         sample_data = 14'h2A5C ^ 14'(i * 14'h0333);
         meas(cmds[i], sample_data, i[0]);
      end
      ureg_rd(8'h40);
      head(`HTC_CMD_SOFT_RST);
      m.stop();
      repeat (15 * MS_CYC) @(posedge clock);
      ureg_rd(8'h00);
      end_sim();
   end
endmodule
bind htc_i2c_port htc_i2c_port_chk #(.MS_CYC(MS_CYC)) u_chk (.clock(clock),
   .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .sample_data(sample_data), .low_supply(low_supply), .conv_busy_r(conv_busy_r),
   .conv_humid_r(conv_humid_r), .heater_en(heater_en), .resolution(resolution),
   .ready(ready));
`default_nettype wire
